// ===== rtl/hrpf_cfg.svh
// Constants of the host packet framer
`ifndef HRPF_CFG_SVH
`define HRPF_CFG_SVH

// ============================================================
// Framing
`define HRPF_START_MARKER 8'hAC
`define HRPF_SUM_ZERO 8'h00
`define HRPF_PARAM_LEN 8'h05
`define HRPF_SYSINFO_LEN 8'h10
`define HRPF_PORTINFO_LEN 8'h11
`define HRPF_EVENT_BYTES 8'h03
`define HRPF_EVENT_MAX 7'h48
`define HRPF_HDR_LAST 8'h03
`define HRPF_WORD_LAST 8'h04

// ============================================================
// Routine codes
`define HRPF_RTN_NONE 8'h00
`define HRPF_RTN_READ_SYSTEM_INFO 8'h02
`define HRPF_RTN_READ_PORT_INFO 8'h08
`define HRPF_RTN_FETCH_EVENTS 8'h2E
`define HRPF_RTN_LAST 8'h3F

// ============================================================
// Timing
`define HRPF_CLK_KHZ 100000
`define HRPF_REPLY_TIMEOUT_MS 1000

`endif

// ===== rtl/hrpf_pkg.sv
// Types shared by both ends of the host packet framer
package hrpf_pkg;

    // ============================================================
    // Basic types
    typedef logic [7:0] hrpf_byte_type;
    typedef logic [31:0] hrpf_word_type;

    // ============================================================
    // State machines
    typedef enum logic [2:0] {
        RX_HUNT, RX_CSUM, RX_RTN, RX_LEN, RX_PAY
    } hrpf_rx_state_type;

    typedef enum logic [2:0] {
        DV_IDLE, DV_CALL, DV_SUM, DV_SEND
    } hrpf_dev_state_type;

    typedef enum logic [1:0] {
        HS_IDLE, HS_SEND, HS_WAIT
    } hrpf_host_state_type;

endpackage : hrpf_pkg

// ===== rtl/hrpf_link_if.sv
// Byte-serial host link between packet client and packet server
interface hrpf_link_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;

    // ============================================================
    // Ends
    modport device (input h2d_data, h2d_valid, d2h_ready, output h2d_ready, d2h_data, d2h_valid);
    modport host (output h2d_data, h2d_valid, d2h_ready, input h2d_ready, d2h_data, d2h_valid);
endinterface : hrpf_link_if

// ===== rtl/hrpf_pkt_rx.sv
// Packet receiver: marker hunt, field parse, checksum check
`include "hrpf_cfg.svh"

module hrpf_pkt_rx (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire hrpf_pkg::hrpf_byte_type byte_i,
    output logic pay_valid_o,
    output hrpf_pkg::hrpf_byte_type pay_idx_o,
    output hrpf_pkg::hrpf_byte_type pay_data_o,
    output logic done_o,
    output logic good_o,
    output hrpf_pkg::hrpf_byte_type routine_o,
    output hrpf_pkg::hrpf_byte_type len_o
);
    import hrpf_pkg::*;

    typedef struct packed {
        hrpf_rx_state_type st;
        hrpf_byte_type sum;
        hrpf_byte_type rtn;
        hrpf_byte_type len;
        hrpf_byte_type cnt;
        hrpf_byte_type pay;
        hrpf_byte_type idx;
        logic pay_v;
        logic done;
        logic good;
    } hrpf_rx_type;

    hrpf_rx_type r_reg;
    hrpf_rx_type r_next;

    // ============================================================
    // Parser
    always_comb begin
        hrpf_byte_type acc;
        acc = r_reg.sum + byte_i;
        r_next = r_reg;
        r_next.pay_v = 1'b0;
        r_next.done = 1'b0;
        if (valid_i) begin
            unique case (r_reg.st)
                RX_HUNT: begin
                    // Anything but the marker is dropped, so lost bytes resync here
                    if (byte_i == `HRPF_START_MARKER) begin
                        r_next.st = RX_CSUM;
                    end
                end
                RX_CSUM: begin
                    r_next.sum = byte_i;
                    r_next.st = RX_RTN;
                end
                RX_RTN: begin
                    r_next.sum = acc;
                    r_next.rtn = byte_i;
                    r_next.st = RX_LEN;
                end
                RX_LEN: begin
                    r_next.sum = acc;
                    r_next.len = byte_i;
                    r_next.cnt = '0;
                    if (byte_i == `HRPF_SUM_ZERO) begin
                        r_next.done = 1'b1;
                        r_next.good = (acc == `HRPF_SUM_ZERO);
                        r_next.st = RX_HUNT;
                    end else begin
                        r_next.st = RX_PAY;
                    end
                end
                RX_PAY: begin
                    r_next.sum = acc;
                    r_next.pay = byte_i;
                    r_next.idx = r_reg.cnt;
                    r_next.pay_v = 1'b1;
                    r_next.cnt = r_reg.cnt + 8'h01;
                    if (r_next.cnt == r_reg.len) begin
                        r_next.done = 1'b1;
                        r_next.good = (acc == `HRPF_SUM_ZERO);
                        r_next.st = RX_HUNT;
                    end
                end
                default: r_next.st = RX_HUNT;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pay_valid_o = r_reg.pay_v;
    assign pay_idx_o = r_reg.idx;
    assign pay_data_o = r_reg.pay;
    assign done_o = r_reg.done;
    assign good_o = r_reg.good;
    assign routine_o = r_reg.rtn;
    assign len_o = r_reg.len;
endmodule : hrpf_pkt_rx

// ===== rtl/hrpf_client.sv
// Host end: sends request packets, matches replies, times out
`include "hrpf_cfg.svh"

module hrpf_client #(
    parameter int unsigned REPLY_TIMEOUT_CYCLES = `HRPF_REPLY_TIMEOUT_MS * `HRPF_CLK_KHZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hrpf_link_if.host link,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire hrpf_pkg::hrpf_byte_type req_routine_i,
    input wire hrpf_pkg::hrpf_byte_type req_byte_i,
    input wire hrpf_pkg::hrpf_word_type req_word_i,
    output logic rsp_valid_o,
    output logic timeout_o,
    output hrpf_pkg::hrpf_byte_type rsp_len_o,
    output hrpf_pkg::hrpf_byte_type rsp_byte_o,
    output hrpf_pkg::hrpf_word_type rsp_word_o,
    output logic pay_valid_o,
    output hrpf_pkg::hrpf_byte_type pay_idx_o,
    output hrpf_pkg::hrpf_byte_type pay_data_o
);
    import hrpf_pkg::*;

    typedef struct packed {
        hrpf_host_state_type st;
        hrpf_byte_type rtn;
        hrpf_byte_type prm8;
        hrpf_word_type prm32;
        hrpf_byte_type csum;
        hrpf_byte_type pos;
        hrpf_byte_type tx;
        logic [31:0] timer;
        hrpf_byte_type rsp8;
        hrpf_word_type rsp32;
        logic rsp_v;
        logic tmo;
    } hrpf_host_type;

    hrpf_host_type r_reg;
    hrpf_host_type r_next;
    logic rx_done, rx_good;
    hrpf_byte_type rx_rtn;

    // ============================================================
    // Reply parser
    hrpf_pkt_rx u_rx (
        .ref_clk_i,
        .rst_n_i,
        .valid_i(link.d2h_valid),
        .byte_i(link.d2h_data),
        .pay_valid_o(pay_valid_o),
        .pay_idx_o(pay_idx_o),
        .pay_data_o(pay_data_o),
        .done_o(rx_done),
        .good_o(rx_good),
        .routine_o(rx_rtn),
        .len_o(rsp_len_o)
    );

    // Byte at a packet position: marker, checksum, routine, length, payload
    function automatic hrpf_byte_type tx_byte(input hrpf_host_type s, input hrpf_byte_type p);
        unique case (p)
            8'h00: tx_byte = `HRPF_START_MARKER;
            8'h01: tx_byte = s.csum;
            8'h02: tx_byte = s.rtn;
            8'h03: tx_byte = `HRPF_PARAM_LEN;
            8'h04: tx_byte = s.prm8;
            8'h05: tx_byte = s.prm32[31:24];
            8'h06: tx_byte = s.prm32[23:16];
            8'h07: tx_byte = s.prm32[15:8];
            default: tx_byte = s.prm32[7:0];
        endcase
    endfunction : tx_byte

    // ============================================================
    // Request and reply sequencing
    always_comb begin
        hrpf_byte_type sum;
        sum = req_routine_i + `HRPF_PARAM_LEN + req_byte_i + req_word_i[31:24]
            + req_word_i[23:16] + req_word_i[15:8] + req_word_i[7:0];
        r_next = r_reg;
        r_next.rsp_v = 1'b0;
        r_next.tmo = 1'b0;
        if (pay_valid_o) begin
            if (pay_idx_o == 8'h00) begin
                r_next.rsp8 = pay_data_o;
            end else if (pay_idx_o <= `HRPF_WORD_LAST) begin
                r_next.rsp32 = {r_reg.rsp32[23:0], pay_data_o};
            end
        end
        unique case (r_reg.st)
            HS_IDLE: begin
                if (req_valid_i) begin
                    r_next.rtn = req_routine_i;
                    r_next.prm8 = req_byte_i;
                    r_next.prm32 = req_word_i;
                    r_next.csum = ~sum + 8'h01;
                    r_next.pos = '0;
                    r_next.tx = `HRPF_START_MARKER;
                    r_next.st = HS_SEND;
                end
            end
            HS_SEND: begin
                if (link.h2d_ready) begin
                    if (r_reg.pos == `HRPF_HDR_LAST + `HRPF_PARAM_LEN) begin
                        r_next.timer = '0;
                        r_next.st = HS_WAIT;
                    end else begin
                        r_next.pos = r_reg.pos + 8'h01;
                        r_next.tx = tx_byte(r_reg, r_next.pos);
                    end
                end
            end
            HS_WAIT: begin
                r_next.timer = r_reg.timer + 32'h1;
                // Mismatched or corrupt replies are ignored; the timer keeps running
                if (rx_done && rx_good && rx_rtn == r_reg.rtn) begin
                    r_next.rsp_v = 1'b1;
                    r_next.st = HS_IDLE;
                end else if (r_reg.timer == REPLY_TIMEOUT_CYCLES - 1) begin
                    r_next.tmo = 1'b1;
                    r_next.st = HS_IDLE;
                end
            end
            default: r_next.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign req_ready_o = (r_reg.st == HS_IDLE);
    assign link.h2d_valid = (r_reg.st == HS_SEND);
    assign link.h2d_data = r_reg.tx;
    assign link.d2h_ready = 1'b1;
    assign rsp_valid_o = r_reg.rsp_v;
    assign timeout_o = r_reg.tmo;
    assign rsp_byte_o = r_reg.rsp8;
    assign rsp_word_o = r_reg.rsp32;
endmodule : hrpf_client

// ===== rtl/hrpf_server.sv
// Device end: validates request packets, dispatches routines, sends replies
//
// Operation
// - Every packet starts with marker byte 0xAC
// - Receiver discards bytes until the marker
// - All fields except payload are one byte
// - Length byte counts payload bytes, 0 to 255
// - Checksum is inverted field sum plus one
// - Receiver sum through checksum must be zero
// - Valid request calls routine, one reply follows
// - Host checks reply routine matches request routine
// - Host requests always use the parameter layout
// - Replies use parameters except three special routines
// - Byte and word parameter always both sent
// - Parameter layout length byte is five
// - Word parameter travels most significant byte first
// - Total power queries ignore parameters, return word
// - Port power queries: port in, word out
// - Port setting writes: port, value in; result out
// - Power limit read in word, others byte
// - Supply status: index in, status byte out
// - Bad checksum or routine gives no reply
// - Host gives up or resends after one second
// - Events are three bytes, at most 72
`include "hrpf_cfg.svh"

module hrpf_server (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    hrpf_link_if.device link,
    output logic call_valid_o,
    output hrpf_pkg::hrpf_byte_type call_routine_o,
    output hrpf_pkg::hrpf_byte_type call_byte_o,
    output hrpf_pkg::hrpf_word_type call_word_o,
    input wire logic call_done_i,
    input wire hrpf_pkg::hrpf_byte_type reply_byte_i,
    input wire hrpf_pkg::hrpf_word_type reply_word_i,
    input wire logic [6:0] event_count_i,
    output hrpf_pkg::hrpf_byte_type fetch_idx_o,
    input wire hrpf_pkg::hrpf_byte_type fetch_data_i,
    output logic drop_o
);
    import hrpf_pkg::*;

    typedef struct packed {
        hrpf_dev_state_type st;
        hrpf_byte_type rtn;
        hrpf_byte_type prm8;
        hrpf_word_type prm32;
        logic special;
        hrpf_byte_type len;
        hrpf_byte_type sum;
        hrpf_byte_type idx;
        hrpf_byte_type tx;
        logic drop;
    } hrpf_dev_type;

    hrpf_dev_type r_reg;
    hrpf_dev_type r_next;
    logic rx_en;
    logic rx_pay_v;
    logic rx_done;
    logic rx_good;
    logic rtn_ok;
    hrpf_byte_type rx_idx, rx_data, rx_rtn, rx_len;
    hrpf_byte_type pay_idx;
    hrpf_byte_type pay_byte, next_pos, ev_len;
    logic [6:0] ev_cnt;

    // ============================================================
    // Request parser
    // Input stalls while a request is in service, so a second request waits
    assign rx_en = link.h2d_valid && (r_reg.st == DV_IDLE);
    assign link.h2d_ready = (r_reg.st == DV_IDLE);

    hrpf_pkt_rx u_rx (
        .ref_clk_i,
        .rst_n_i,
        .valid_i(rx_en),
        .byte_i(link.h2d_data),
        .pay_valid_o(rx_pay_v),
        .pay_idx_o(rx_idx),
        .pay_data_o(rx_data),
        .done_o(rx_done),
        .good_o(rx_good),
        .routine_o(rx_rtn),
        .len_o(rx_len)
    );

    assign rtn_ok = (rx_rtn != `HRPF_RTN_NONE) && (rx_rtn <= `HRPF_RTN_LAST);

    // ============================================================
    // Reply payload source
    // Event count is clamped so a runaway queue cannot overrun the length byte
    assign ev_cnt = (event_count_i > `HRPF_EVENT_MAX) ? `HRPF_EVENT_MAX : event_count_i;
    assign ev_len = 8'({1'b0, ev_cnt} * `HRPF_EVENT_BYTES);
    assign next_pos = r_reg.idx + 8'h01;
    assign pay_idx = (r_reg.st == DV_SUM) ? r_reg.idx : next_pos - `HRPF_HDR_LAST - 8'h01;
    assign fetch_idx_o = pay_idx;

    always_comb begin
        if (r_reg.special) begin
            pay_byte = fetch_data_i;
        end else begin
            unique case (pay_idx)
                8'h00: pay_byte = r_reg.prm8;
                8'h01: pay_byte = r_reg.prm32[31:24];
                8'h02: pay_byte = r_reg.prm32[23:16];
                8'h03: pay_byte = r_reg.prm32[15:8];
                default: pay_byte = r_reg.prm32[7:0];
            endcase
        end
    end

    // ============================================================
    // Dispatch and reply sequencing
    always_comb begin
        r_next = r_reg;
        r_next.drop = 1'b0;
        unique case (r_reg.st)
            DV_IDLE: begin
                if (rx_pay_v) begin
                    if (rx_idx == 8'h00) begin
                        r_next.prm8 = rx_data;
                    end else if (rx_idx <= `HRPF_WORD_LAST) begin
                        r_next.prm32 = {r_reg.prm32[23:0], rx_data};
                    end
                end
                if (rx_done) begin
                    // Only a checked, five-byte, known-routine request is served
                    if (rx_good && rtn_ok && rx_len == `HRPF_PARAM_LEN) begin
                        r_next.rtn = rx_rtn;
                        r_next.st = DV_CALL;
                    end else begin
                        r_next.drop = 1'b1;
                    end
                end
            end
            DV_CALL: begin
                if (call_done_i) begin
                    r_next.prm8 = reply_byte_i;
                    r_next.prm32 = reply_word_i;
                    r_next.special = 1'b1;
                    unique case (r_reg.rtn)
                        `HRPF_RTN_READ_SYSTEM_INFO: r_next.len = `HRPF_SYSINFO_LEN;
                        `HRPF_RTN_READ_PORT_INFO: r_next.len = `HRPF_PORTINFO_LEN;
                        `HRPF_RTN_FETCH_EVENTS: r_next.len = ev_len;
                        default: begin
                            r_next.special = 1'b0;
                            r_next.len = `HRPF_PARAM_LEN;
                        end
                    endcase
                    r_next.sum = r_reg.rtn;
                    r_next.idx = '0;
                    r_next.st = DV_SUM;
                end
            end
            DV_SUM: begin
                // Checksum goes out before the payload, so the payload is walked twice
                if (r_reg.idx == r_reg.len) begin
                    r_next.sum = ~(r_reg.sum + r_reg.len) + 8'h01;
                    r_next.idx = '0;
                    r_next.tx = `HRPF_START_MARKER;
                    r_next.st = DV_SEND;
                end else begin
                    r_next.sum = r_reg.sum + pay_byte;
                    r_next.idx = next_pos;
                end
            end
            DV_SEND: begin
                if (link.d2h_ready) begin
                    if (r_reg.idx == r_reg.len + `HRPF_HDR_LAST) begin
                        r_next.st = DV_IDLE;
                    end else begin
                        r_next.idx = next_pos;
                        unique case (next_pos)
                            8'h01: r_next.tx = r_reg.sum;
                            8'h02: r_next.tx = r_reg.rtn;
                            8'h03: r_next.tx = r_reg.len;
                            default: r_next.tx = pay_byte;
                        endcase
                    end
                end
            end
            default: r_next.st = DV_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ============================================================
    // Outputs
    assign call_valid_o = (r_reg.st == DV_CALL);
    assign call_routine_o = r_reg.rtn;
    assign call_byte_o = r_reg.prm8;
    assign call_word_o = r_reg.prm32;
    assign link.d2h_valid = (r_reg.st == DV_SEND);
    assign link.d2h_data = r_reg.tx;
    assign drop_o = r_reg.drop;
endmodule : hrpf_server

// ===== rtl/hrpf_server_end.sv
// Spare file: holds no logic

// ===== dv/hrpf_link_properties.sv
// Link checker: packet position trackers and assertions on the host link
// ============================================================
// Tracker
module hrpf_pkt_track (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic take_i,
    input logic [7:0] data_i,
    output logic [8:0] pos_o,
    output logic [7:0] len_o,
    output logic [7:0] sum_o,
    output logic [7:0] rtn_o,
    output logic last_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Zero length ends the packet on the length byte itself
    assign last_o = take_i && ((pos_o == 9'h003 && data_i == 8'h00) ||
                    (pos_o > 9'h003 && pos_o == {1'b0, len_o} + 9'h003));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_o <= '0;
            len_o <= '0;
            sum_o <= '0;
            rtn_o <= '0;
        end else if (take_i) begin
            pos_o <= last_o ? 9'h000 : pos_o + 9'h001;
            sum_o <= (pos_o == 9'h000) ? 8'h00 : sum_o + data_i;
            if (pos_o == 9'h002) rtn_o <= data_i;
            if (pos_o == 9'h003) len_o <= data_i;
        end
    end
endmodule : hrpf_pkt_track

// ============================================================
// Checker
module hrpf_link_properties (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic [7:0] h2d_data,
    input logic h2d_valid,
    input logic h2d_ready,
    input logic [7:0] d2h_data,
    input logic d2h_valid,
    input logic d2h_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic h_last, d_last;
    logic [8:0] h_pos, d_pos;
    logic [7:0] h_len, d_len, h_sum, d_sum, h_rtn, d_rtn;
    hrpf_pkt_track i_hrpf_pkt_track_h (.ref_clk_i, .rst_n_i,
        .take_i(h2d_valid && h2d_ready), .data_i(h2d_data), .pos_o(h_pos), .len_o(h_len),
        .sum_o(h_sum), .rtn_o(h_rtn), .last_o(h_last));
    hrpf_pkt_track i_hrpf_pkt_track_d (.ref_clk_i, .rst_n_i,
        .take_i(d2h_valid && d2h_ready), .data_i(d2h_data), .pos_o(d_pos), .len_o(d_len),
        .sum_o(d_sum), .rtn_o(d_rtn), .last_o(d_last));
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_h2d_start: assert property (h2d_valid && h_pos == 9'h000 |-> h2d_data == 8'hAC)
        else $error("no request marker");
    chk_d2h_start: assert property (d2h_valid && d_pos == 9'h000 |-> d2h_data == 8'hAC)
        else $error("no reply marker");
    chk_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
        else $error("request byte moved");
    chk_req_len_five: assert property (h2d_valid && h2d_ready && h_pos == 9'h003 |-> h2d_data == 8'h05)
        else $error("request length");
    chk_h2d_sum: assert property (h_last |-> 8'(h_sum + h2d_data) == 8'h00)
        else $error("request checksum");
    chk_d2h_sum: assert property (d_last |-> 8'(d_sum + d2h_data) == 8'h00)
        else $error("reply checksum");
    chk_reply_len: assert property (d2h_valid && d_pos == 9'h003 &&
        !(d_rtn inside {8'h02, 8'h08, 8'h2E}) |-> d2h_data == 8'h05) else $error("reply length");
    chk_reply_rtn: assert property (d2h_valid && d_pos == 9'h002 |-> d2h_data == h_rtn)
        else $error("reply routine");
    chk_rx_blocked: assert property (d2h_valid |-> !h2d_ready)
        else $error("accepts while replying");
    chk_event_len: assert property (d2h_valid && d_pos == 9'h003 && d_rtn == 8'h2E |->
        d2h_data <= 8'hD8 && d2h_data % 8'h03 == 8'h00) else $error("event length");
endmodule : hrpf_link_properties

// ===== dv/host_rpc_packet_framer_test.sv
// Testbench: client and server joined, plus a fault-fed server
module host_rpc_packet_framer_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 0;
    logic rst_n_i = 0;
    logic req_valid, done, done2, spec, req_ready, rsp_valid, timeout, pay_valid;
    logic call_valid, call_valid2, drop, drop2;
    logic [7:0] req_rtn, req_b, rb, rsp_len, rsp_byte, pay_idx, pay_data, fetch_idx;
    logic [7:0] call_rtn, call_b, call_rtn2, call_b2;
    logic [31:0] req_w, rw, rsp_word, call_w, call_w2;
    logic [6:0] cnt;
    logic [48:0] exp_q[$], msk_q[$], q2[$];
    logic [47:0] call_q[$];
    logic [7:0] rt[8] = '{8'h01, 8'h03, 8'h0A, 8'h10, 8'h12, 8'h16, 8'h1F, 8'h3F};
    int n_mismatch = 0;
    int n_tests = 0;
    hrpf_link_if link();
    hrpf_link_if link2();
    always #5 ref_clk_i = ~ref_clk_i;
    // ============================================================
    // Ends and checker
    hrpf_client #(.REPLY_TIMEOUT_CYCLES(2000)) i_hrpf_client (.ref_clk_i,
        .rst_n_i, .link(link.host), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .req_routine_i(req_rtn), .req_byte_i(req_b), .req_word_i(req_w),
        .rsp_valid_o(rsp_valid), .timeout_o(timeout), .rsp_len_o(rsp_len),
        .rsp_byte_o(rsp_byte), .rsp_word_o(rsp_word), .pay_valid_o(pay_valid),
        .pay_idx_o(pay_idx), .pay_data_o(pay_data));
    hrpf_server i_hrpf_server (.ref_clk_i, .rst_n_i, .link(link.device),
        .call_valid_o(call_valid), .call_routine_o(call_rtn), .call_byte_o(call_b),
        .call_word_o(call_w), .call_done_i(done), .reply_byte_i(rb), .reply_word_i(rw),
        .event_count_i(cnt), .fetch_idx_o(fetch_idx), .fetch_data_i(fetch_idx ^ 8'h5A),
        .drop_o(drop));
    // Second server fed by the bench, for fault injection
    hrpf_server i_hrpf_server_2 (.ref_clk_i, .rst_n_i,
        .link(link2.device), .call_valid_o(call_valid2), .call_routine_o(call_rtn2),
        .call_byte_o(call_b2), .call_word_o(call_w2), .call_done_i(done2),
        .reply_byte_i(8'h00), .reply_word_i(32'h0), .event_count_i(7'h00), .fetch_idx_o(),
        .fetch_data_i(8'h00), .drop_o(drop2));
    hrpf_link_properties i_hrpf_link_properties (.ref_clk_i, .rst_n_i,
        .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
        .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
    // ============================================================
    // Tasks
    task check(input logic [48:0] seen, input logic [48:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task req(input logic [7:0] r, input logic [6:0] c, input logic [7:0] el, input logic sp,
             input logic to);
        logic [48:0] m;
        m = to ? 49'h1_0000_0000_0000 : (sp ? 49'h1_FF00_0000_0000 : '1);
        rb = 8'($urandom);
        rw = $urandom;
        cnt = c;
        spec = sp;
        req_rtn = r;
        req_b = 8'($urandom);
        req_w = $urandom;
        exp_q.push_back({to, el, rb, rw} & m);
        msk_q.push_back(m);
        if (!to) call_q.push_back({r, req_b, req_w});
        req_valid = 1;
        do @(negedge ref_clk_i); while (req_ready !== 1'b1);
        @(posedge ref_clk_i) #1 req_valid = 0;
        while (exp_q.size() != 0) @(posedge ref_clk_i);
        #1;
    endtask : req
    task send2(input logic [7:0] r, input logic [7:0] l, input logic [7:0] cerr,
               input logic drop_exp);
        logic [7:0] b[10];
        logic [7:0] s;
        s = r + l + ((l == 8'h05) ? 8'h11 : 8'h0A);
        b = '{8'h11, 8'hAC, 8'(~s + 8'h01 + cerr), r, l, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04};
        q2.push_back(drop_exp ? 49'h1_0000_0000_0000 : {1'b0, r, 40'h07_0102_0304});
        foreach (b[i]) begin
            link2.h2d_data = b[i];
            link2.h2d_valid = 1;
            do @(negedge ref_clk_i); while (link2.h2d_ready !== 1'b1);
            @(posedge ref_clk_i) #1;
        end
        link2.h2d_valid = 0;
        while (q2.size() != 0) @(posedge ref_clk_i);
        #1;
    endtask : send2
    // ============================================================
    // Monitors and routine responders
    always @(negedge ref_clk_i) begin
        if (rsp_valid === 1'b1 || timeout === 1'b1) begin
            if (exp_q.size() == 0) check(49'h0, 49'h1);
            else check({timeout, rsp_len, rsp_byte, rsp_word} & msk_q.pop_front(), exp_q.pop_front());
        end
        if (pay_valid === 1'b1 && spec) check(pay_data, pay_idx ^ 8'h5A);
        if (drop === 1'b1) check(req_rtn, 8'h40);
    end
    always @(negedge ref_clk_i) begin
        if (call_valid === 1'b1 && done !== 1'b1) begin
            check({call_rtn, call_b, call_w}, call_q.pop_front());
            repeat ($urandom_range(3)) @(posedge ref_clk_i);
            @(posedge ref_clk_i) #1 done = 1;
            @(posedge ref_clk_i) #1 done = 0;
        end
    end
    always @(negedge ref_clk_i) begin
        if (drop2 === 1'b1) check(49'h1_0000_0000_0000, q2.pop_front());
        if (call_valid2 === 1'b1 && done2 !== 1'b1) begin
            check({call_rtn2, call_b2, call_w2}, q2.pop_front());
            @(posedge ref_clk_i) #1 done2 = 1;
            @(posedge ref_clk_i) #1 done2 = 0;
        end
    end
    // ============================================================
    // Sequence
    initial begin
        void'($urandom(29));
        {req_valid, done, done2, spec, rb, rw, cnt, req_rtn, req_b, req_w} = '0;
        link2.h2d_valid = 0;
        link2.h2d_data = 8'h00;
        link2.d2h_ready = 1;
        repeat (6) @(posedge ref_clk_i);
        #1 rst_n_i = 1;
        foreach (rt[i]) req(rt[i], 7'h00, 8'h05, 0, 0);
        req(8'h02, 7'h00, 8'h10, 1, 0);
        req(8'h08, 7'h00, 8'h11, 1, 0);
        req(8'h2E, 7'h00, 8'h00, 1, 0);
        req(8'h2E, 7'h48, 8'hD8, 1, 0);
        req(8'h2E, 7'h64, 8'hD8, 1, 0);
        req(8'h40, 7'h00, 8'h00, 0, 1);
        req(8'h01, 7'h00, 8'h05, 0, 0);
        send2(8'h01, 8'h05, 8'h00, 0);
        send2(8'h01, 8'h05, 8'h01, 1);
        send2(8'h00, 8'h05, 8'h00, 1);
        send2(8'h40, 8'h05, 8'h00, 1);
        send2(8'h01, 8'h03, 8'h00, 1);
        send2(8'h3F, 8'h05, 8'h00, 0);
        results();
    end
    // Span covers one reply timeout and the longest event reply with margin
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule : host_rpc_packet_framer_test
